// *** bench/flash_writer_model.sv ***
// Behavioural serial writer on the far side of the programming pins
`timescale 1ns/1ps
module flash_writer_model #(
    parameter int AW = 12,
    parameter int WW = 15
) (
    input wire logic dev_o,
    input wire logic dev_oe_n,
    output logic pin_data,
    output logic pin_clk,
    output logic clear_n
);
    logic drv = 1'b1;
    logic dat = 1'b0;
    logic float_v = 1'b0;
    initial begin
        pin_clk = 1'b0;
        clear_n = 1'b1;
    end
    // Released line toggles so a missing drive never looks valid
    assign pin_data = !dev_oe_n ? dev_o : (drv ? dat : float_v);
    always #50 float_v = (dev_oe_n && !drv) ? ~float_v : ~pin_data;
    task automatic bit_out(input logic b, input logic rel);
        begin
            dat = b;
            #200 pin_clk = 1'b1;
            // Hold data past the device's two-stage sampling before release
            #100;
            if (rel)
                drv = 1'b0;
            #100 pin_clk = 1'b0;
        end
    endtask : bit_out
    task automatic write_word(input logic [AW-1:0] a, input logic [WW-1:0] d);
        logic [AW+WW:0] f;
        begin
            f = {1'b1, a, d};
            for (int i = AW + WW; i >= 0; i--) begin
                bit_out(f[i], 1'b0);
            end
            #200;
        end
    endtask : write_word
    task automatic read_word(input logic [AW-1:0] a, output logic [WW-1:0] d);
        logic [AW:0] f;
        begin
            f = {1'b0, a};
            for (int i = AW; i >= 0; i--) begin
                bit_out(f[i], i == 0);
            end
            // Sample at the rise; the device lets go a few cycles after the last one
            for (int i = WW - 1; i >= 0; i--) begin
                #200 pin_clk = 1'b1;
                d[i] = pin_data;
                #200 pin_clk = 1'b0;
            end
            #100 drv = 1'b1;
        end
    endtask : read_word
    task automatic hold_clear(input logic lvl);
        begin
            clear_n = lvl;
            #400;
        end
    endtask : hold_clear
endmodule : flash_writer_model

// *** bench/testbench.sv ***
// Self-checking bench for the program memory access block
`timescale 1ns/1ps
module testbench;
    import pmem_pkg::*;
    logic sys_clk, sys_rst, pc_step, pc_load, program_counter_low_byte_wr;
    logic table_low_ptr_wr, table_high_ptr_wr, table_read_req;
    logic [11:0] pc_load_addr, program_counter;
    logic [7:0] sfr_wdata, table_read_dest, table_low_ptr, table_high_ptr;
    logic [7:0] table_done_dest, table_done_low_byte, table_high_byte_latch;
    tbl_mode_t table_read_mode;
    logic [14:0] fetch_word;
    logic table_busy, table_done, core_suspend, clear_n, pa0_lvl, pa2_lvl, w_clk;
    logic port_a_bit0_o, port_a_bit0_oe_n, port_a_bit2_o, port_a_bit2_oe_n;
    logic gpio_a0_out, gpio_a0_oe_n, gpio_a2_out, gpio_a2_oe_n, gpio_a0_in, gpio_a2_in;
    logic [14:0] img [4096];
    logic [11:0] wa [6] = '{12'h000, 12'h001, 12'h2A3, 12'h105, 12'hF06, 12'hF05};
    logic [14:0] wd [6] = '{15'h1234, 15'h7ABC, 15'h5A5A, 15'h4321, 15'h001A, 15'h7F0F};
    logic [7:0] lo_v, lat_v;
    int bad_count = 0;
    int samples_checked = 0;
    assign pa2_lvl = !port_a_bit2_oe_n ? port_a_bit2_o : w_clk;
    program_memory_table_read dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .pc_step(pc_step),
        .pc_load(pc_load), .pc_load_addr(pc_load_addr),
        .program_counter_low_byte_wr(program_counter_low_byte_wr),
        .table_low_ptr_wr(table_low_ptr_wr), .table_high_ptr_wr(table_high_ptr_wr),
        .sfr_wdata(sfr_wdata), .table_read_req(table_read_req),
        .table_read_mode(table_read_mode), .table_read_dest(table_read_dest),
        .program_counter(program_counter), .fetch_word(fetch_word),
        .table_low_ptr(table_low_ptr), .table_high_ptr(table_high_ptr),
        .table_busy(table_busy), .table_done(table_done), .table_done_dest(table_done_dest),
        .table_done_low_byte(table_done_low_byte),
        .table_high_byte_latch(table_high_byte_latch), .core_suspend(core_suspend),
        .external_clear_pin_n(clear_n), .port_a_bit0_i(pa0_lvl),
        .port_a_bit0_o(port_a_bit0_o), .port_a_bit0_oe_n(port_a_bit0_oe_n),
        .port_a_bit2_i(pa2_lvl), .port_a_bit2_o(port_a_bit2_o),
        .port_a_bit2_oe_n(port_a_bit2_oe_n), .gpio_a0_out(gpio_a0_out),
        .gpio_a0_oe_n(gpio_a0_oe_n), .gpio_a2_out(gpio_a2_out), .gpio_a2_oe_n(gpio_a2_oe_n),
        .gpio_a0_in(gpio_a0_in), .gpio_a2_in(gpio_a2_in));
    flash_writer_model writer_u (.dev_o(port_a_bit0_o), .dev_oe_n(port_a_bit0_oe_n),
        .pin_data(pa0_lvl), .pin_clk(w_clk), .clear_n(clear_n));
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim
    task automatic tick;
        @(posedge sys_clk);
        #2;
    endtask : tick
    task automatic set_ptr(input logic [7:0] hi, input logic [7:0] lo);
        tick();
        table_high_ptr_wr = 1'b1;
        sfr_wdata = hi;
        tick();
        table_high_ptr_wr = 1'b0;
        table_low_ptr_wr = 1'b1;
        sfr_wdata = lo;
        tick();
        table_low_ptr_wr = 1'b0;
        lo_v = lo;
        chk("pointers", {table_high_ptr, table_low_ptr}, {hi, lo});
        chk("latch_kept", 16'(table_high_byte_latch), 16'(lat_v));
    endtask : set_ptr
    // Poke holds the request into the busy cycle and tries a pointer write there
    task automatic tbl_read(input tbl_mode_t m, input logic [7:0] d, input logic [11:0] a,
                            input logic poke);
        logic [14:0] w;
        w = img[a];
        tick();
        table_read_req = 1'b1;
        table_read_mode = m;
        table_read_dest = d;
        tick();
        chk("busy_c1", 16'(table_busy), 16'h0001);
        chk("done_c1", 16'(table_done), 16'h0000);
        table_read_req = poke;
        table_low_ptr_wr = poke;
        sfr_wdata = ~lo_v;
        tick();
        table_low_ptr_wr = 1'b0;
        chk("done_c2", {table_done, table_busy}, 16'h0002);
        chk("dest", 16'(table_done_dest), 16'(d));
        chk("low_byte", 16'(table_done_low_byte), 16'(w[7:0]));
        chk("latch", 16'(table_high_byte_latch), {9'h000, w[14:8]});
        chk("ptr_refused", 16'(table_low_ptr), 16'(lo_v));
        lat_v = {1'b0, w[14:8]};
        if (poke) begin
            tick();
            table_read_req = 1'b0;
            chk("back_to_back", {table_done, table_busy}, 16'h0001);
            tick();
            chk("second_done", {table_done, table_done_low_byte}, {8'h01, w[7:0]});
        end
        tick();
        chk("done_drop", 16'(table_done), 16'h0000);
        chk("latch_hold", 16'(table_high_byte_latch), 16'(lat_v));
    endtask : tbl_read
    task automatic program_words;
        logic [14:0] rd;
        tick();
        gpio_a0_oe_n = 1'b0;
        gpio_a2_oe_n = 1'b0;
        pc_step = 1'b1;
        // User drive settles first, so its edge is not taken as a serial clock
        tick();
        writer_u.hold_clear(1'b0);
        chk("suspend", 16'(core_suspend), 16'h0001);
        for (int i = 0; i < 6; i++) begin
            img[wa[i]] = wd[i];
            writer_u.write_word(wa[i], wd[i]);
        end
        chk("clk_pin", {port_a_bit2_oe_n, port_a_bit2_o}, 16'h0002);
        chk("data_pin_oe_n", 16'(port_a_bit0_oe_n), 16'h0001);
        chk("pc_held", 16'(program_counter), 16'h0000);
        writer_u.read_word(12'h2A3, rd);
        chk("read_back", 16'(rd), 16'(img[12'h2A3]));
        writer_u.read_word(12'hF05, rd);
        chk("read_back", 16'(rd), 16'(img[12'hF05]));
        tick();
        pc_step = 1'b0;
        writer_u.hold_clear(1'b1);
    endtask : program_words
    task automatic run_after_release;
        tick();
        chk("suspend_off", 16'(core_suspend), 16'h0000);
        chk("pin0_user", {port_a_bit0_oe_n, port_a_bit0_o, gpio_a0_in}, 16'h0003);
        chk("pin2_user", {port_a_bit2_oe_n, port_a_bit2_o, gpio_a2_in}, 16'h0003);
        chk("pc_start", 16'(program_counter), 16'h0000);
        chk("fetch0", 16'(fetch_word), 16'(img[12'h000]));
        pc_step = 1'b1;
        tick();
        pc_step = 1'b0;
        chk("pc_step", 16'(program_counter), 16'h0001);
        tick();
        chk("fetch1", 16'(fetch_word), 16'(img[12'h001]));
    endtask : run_after_release
    // The last-page poke read holds its request into the busy cycle; the repeat is taken back-to-back
    task automatic table_reads;
        set_ptr(8'h02, 8'hA3);
        tbl_read(MODE_FULL, 8'h55, 12'h2A3, 1'b0);
        set_ptr(8'h02, 8'h06);
        tbl_read(MODE_LAST, 8'h31, 12'hF06, 1'b0);
        set_ptr(8'h02, 8'h05);
        tbl_read(MODE_LAST, 8'h32, 12'hF05, 1'b1);
        pc_load = 1'b1;
        pc_load_addr = 12'h1C0;
        tick();
        pc_load = 1'b0;
        program_counter_low_byte_wr = 1'b1;
        sfr_wdata = 8'h42;
        tick();
        program_counter_low_byte_wr = 1'b0;
        chk("pc_low_write", 16'(program_counter), 16'h0142);
        tbl_read(MODE_PAGE, 8'hC7, 12'h105, 1'b0);
    endtask : table_reads
    task automatic second_reset;
        pc_load = 1'b1;
        pc_load_addr = 12'h3FF;
        tick();
        pc_load = 1'b0;
        sys_rst = 1'b1;
        chk("pc_loaded", 16'(program_counter), 16'h03FF);
        tick();
        sys_rst = 1'b0;
        chk("pc_reset", 16'(program_counter), 16'h0000);
        chk("latch_reset", 16'(table_high_byte_latch), 16'h0000);
    endtask : second_reset
    // Every wait in the run is bounded by this watchdog
    initial begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        end_sim();
    end
    initial begin
        {sys_rst, pc_step, pc_load, program_counter_low_byte_wr} = 4'h8;
        {table_low_ptr_wr, table_high_ptr_wr, table_read_req} = 3'h0;
        {gpio_a0_out, gpio_a0_oe_n, gpio_a2_out, gpio_a2_oe_n} = 4'hF;
        pc_load_addr = 12'h000;
        sfr_wdata = 8'h00;
        table_read_dest = 8'h00;
        table_read_mode = MODE_FULL;
        lat_v = 8'h00;
        lo_v = 8'h00;
        repeat (4) @(posedge sys_clk);
        #2 sys_rst = 1'b0;
        chk("reset_state", {program_counter, table_done, table_busy}, 16'h0000);
        program_words();
        run_after_release();
        table_reads();
        second_reset();
        end_sim();
    end
endmodule : testbench

// *** verilog/pmem_array.sv ***
// Flip-flop program word array with two read ports and one write port
`timescale 1ns/1ps
module pmem_array #(
    parameter int AW = 12,
    parameter int WW = 15
) (
    input wire logic sys_clk,
    pmem_if.mem bus
);
    logic [WW-1:0] word_r [2**AW];

    // Storage has no reset; an unprogrammed word is undefined
    always_ff @(posedge sys_clk) begin
        if (bus.wr_en) begin
            word_r[bus.wr_addr] <= bus.wr_data;
        end
    end

    assign bus.fetch_data = word_r[bus.fetch_addr];
    assign bus.rd_data = word_r[bus.rd_addr];
endmodule : pmem_array

// *** verilog/pmem_cfg.svh ***
// Sizes, widths and reset value of the program memory block
`ifndef PMEM_CFG_SVH
`define PMEM_CFG_SVH
`define PMEM_AW_DEF 12
`define PMEM_WW_DEF 15
`define PMEM_PAGE_W 8
`define PMEM_BYTE_W 8
`define PMEM_CNT_W 5
`define PMEM_DEST_W 8
`define PMEM_PC_RESET 12'h000
`endif

// *** verilog/pmem_if.sv ***
// Ports between the access logic and the program word array
`timescale 1ns/1ps
interface pmem_if #(
    parameter int AW = 12,
    parameter int WW = 15
);
    logic [AW-1:0] fetch_addr;
    logic [WW-1:0] fetch_data;
    logic [AW-1:0] rd_addr;
    logic [WW-1:0] rd_data;
    logic wr_en;
    logic [AW-1:0] wr_addr;
    logic [WW-1:0] wr_data;
    modport ctrl (output fetch_addr, rd_addr, wr_en, wr_addr, wr_data,
                  input fetch_data, rd_data);
    modport mem (input fetch_addr, rd_addr, wr_en, wr_addr, wr_data,
                 output fetch_data, rd_data);
endinterface : pmem_if

// *** verilog/pmem_pkg.sv ***
// Types shared by the program memory block
package pmem_pkg;
    typedef enum logic {
        T_IDLE = 1'h0,
        T_READ = 1'h1
    } tbl_state_t;
    typedef enum logic [1:0] {
        S_CMD = 2'h0,
        S_ADDR = 2'h1,
        S_DIN = 2'h3,
        S_DOUT = 2'h2
    } ser_state_t;
    typedef enum logic [1:0] {
        MODE_FULL = 2'h0,
        MODE_PAGE = 2'h1,
        MODE_LAST = 2'h2
    } tbl_mode_t;
endpackage : pmem_pkg

// *** verilog/program_memory_table_read.sv ***
// Program memory access: counter, table reads and serial programming port
`timescale 1ns/1ps
`include "pmem_cfg.svh"
module program_memory_table_read
    import pmem_pkg::*;
#(
    parameter int AW = `PMEM_AW_DEF,
    parameter int WW = `PMEM_WW_DEF
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic pc_step,
    input wire logic pc_load,
    input wire logic [AW-1:0] pc_load_addr,
    input wire logic program_counter_low_byte_wr,
    input wire logic table_low_ptr_wr,
    input wire logic table_high_ptr_wr,
    input wire logic [`PMEM_BYTE_W-1:0] sfr_wdata,
    input wire logic table_read_req,
    input wire tbl_mode_t table_read_mode,
    input wire logic [`PMEM_DEST_W-1:0] table_read_dest,
    output logic [AW-1:0] program_counter,
    output logic [WW-1:0] fetch_word,
    output logic [`PMEM_BYTE_W-1:0] table_low_ptr,
    output logic [`PMEM_BYTE_W-1:0] table_high_ptr,
    output logic table_busy,
    output logic table_done,
    output logic [`PMEM_DEST_W-1:0] table_done_dest,
    output logic [`PMEM_BYTE_W-1:0] table_done_low_byte,
    output logic [`PMEM_BYTE_W-1:0] table_high_byte_latch,
    output logic core_suspend,
    input wire logic external_clear_pin_n,
    input wire logic port_a_bit0_i,
    output logic port_a_bit0_o,
    output logic port_a_bit0_oe_n,
    input wire logic port_a_bit2_i,
    output logic port_a_bit2_o,
    output logic port_a_bit2_oe_n,
    input wire logic gpio_a0_out,
    input wire logic gpio_a0_oe_n,
    input wire logic gpio_a2_out,
    input wire logic gpio_a2_oe_n,
    output logic gpio_a0_in,
    output logic gpio_a2_in
);
    localparam int HW = AW - `PMEM_PAGE_W;
    pmem_if #(.AW(AW), .WW(WW)) mbus ();
    pmem_array #(.AW(AW), .WW(WW)) u_array (.sys_clk(sys_clk), .bus(mbus));
    // Pins come from outside; two stages before any use
    logic d_s1_r, d_s2_r, c_s1_r, c_s2_r, c_d_r, r_s1_r, r_s2_r;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            {d_s1_r, d_s2_r, c_s1_r, c_s2_r, c_d_r} <= '0;
            {r_s1_r, r_s2_r} <= '1;
        end else begin
            d_s1_r <= port_a_bit0_i;
            d_s2_r <= d_s1_r;
            c_s1_r <= port_a_bit2_i;
            c_s2_r <= c_s1_r;
            c_d_r <= c_s2_r;
            r_s1_r <= external_clear_pin_n;
            r_s2_r <= r_s1_r;
        end
    end
    logic prog_mode, clk_rise, clk_fall;
    assign prog_mode = ~r_s2_r;
    assign clk_rise = c_s2_r & ~c_d_r;
    assign clk_fall = ~c_s2_r & c_d_r;
    // Program counter and table pointers
    logic [AW-1:0] pc_r, pc_nxt;
    logic [`PMEM_BYTE_W-1:0] tblp_r, tblp_nxt, tbhp_r, tbhp_nxt;
    logic [WW-1:0] fw_r, fw_nxt;
    always_comb begin
        pc_nxt = pc_r;
        tblp_nxt = tblp_r;
        tbhp_nxt = tbhp_r;
        fw_nxt = mbus.fetch_data;
        if (prog_mode) begin
            pc_nxt = AW'(`PMEM_PC_RESET);
        end else if (!table_busy) begin
            if (pc_load) begin
                pc_nxt = pc_load_addr;
            end else if (program_counter_low_byte_wr) begin
                pc_nxt = {pc_r[AW-1:`PMEM_PAGE_W], sfr_wdata};
            end else if (pc_step) begin
                pc_nxt = AW'(pc_r + 1'b1);
            end
            if (table_low_ptr_wr) begin
                tblp_nxt = sfr_wdata;
            end
            if (table_high_ptr_wr) begin
                tbhp_nxt = sfr_wdata;
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pc_r <= AW'(`PMEM_PC_RESET);
            {tblp_r, tbhp_r, fw_r} <= '0;
        end else begin
            pc_r <= pc_nxt;
            {tblp_r, tbhp_r, fw_r} <= {tblp_nxt, tbhp_nxt, fw_nxt};
        end
    end
    // Table read: accept cycle, then read cycle with the core held
    tbl_state_t ts_r, ts_nxt;
    logic [AW-1:0] ta_r, ta_nxt;
    logic [`PMEM_DEST_W-1:0] dst_r, dst_nxt, ddst_r, ddst_nxt;
    logic [`PMEM_BYTE_W-1:0] lo_r, lo_nxt, hi_r, hi_nxt;
    logic done_r, done_nxt, accept;
    assign accept = table_read_req && ts_r == T_IDLE && !prog_mode;
    always_comb begin
        ts_nxt = ts_r;
        ta_nxt = ta_r;
        dst_nxt = dst_r;
        ddst_nxt = ddst_r;
        lo_nxt = lo_r;
        hi_nxt = hi_r;
        done_nxt = 1'b0;
        case (ts_r)
            T_IDLE: begin
                if (accept) begin
                    ts_nxt = T_READ;
                    dst_nxt = table_read_dest;
                    case (table_read_mode)
                        MODE_PAGE: ta_nxt = {pc_r[AW-1:`PMEM_PAGE_W], tblp_r};
                        MODE_LAST: ta_nxt = {{HW{1'b1}}, tblp_r};
                        default: ta_nxt = {tbhp_r[HW-1:0], tblp_r};
                    endcase
                end
            end
            T_READ: begin
                ts_nxt = T_IDLE;
                done_nxt = 1'b1;
                ddst_nxt = dst_r;
                lo_nxt = mbus.rd_data[`PMEM_BYTE_W-1:0];
                // Zero extension keeps unused latch bits at zero
                hi_nxt = `PMEM_BYTE_W'(mbus.rd_data[WW-1:`PMEM_BYTE_W]);
            end
            default: ts_nxt = T_IDLE;
        endcase
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ts_r <= T_IDLE;
            {ta_r, dst_r, ddst_r, lo_r, hi_r, done_r} <= '0;
        end else begin
            ts_r <= ts_nxt;
            {ta_r, dst_r, ddst_r, lo_r, hi_r, done_r} <=
                {ta_nxt, dst_nxt, ddst_nxt, lo_nxt, hi_nxt, done_nxt};
        end
    end
    // Serial programming: command bit, address, then data in or out
    ser_state_t ps_r, ps_nxt;
    logic [`PMEM_CNT_W-1:0] cnt_r, cnt_nxt;
    logic [AW-1:0] pa_r, pa_nxt;
    logic [WW-1:0] sh_r, sh_nxt;
    logic wcmd_r, wcmd_nxt, drv_r, drv_nxt, out_r, out_nxt, we_r, we_nxt;
    always_comb begin
        ps_nxt = ps_r;
        cnt_nxt = cnt_r;
        pa_nxt = pa_r;
        sh_nxt = sh_r;
        wcmd_nxt = wcmd_r;
        drv_nxt = drv_r;
        out_nxt = out_r;
        we_nxt = 1'b0;
        if (!prog_mode) begin
            ps_nxt = S_CMD;
            cnt_nxt = '0;
            drv_nxt = 1'b0;
        end else begin
            case (ps_r)
                S_CMD: begin
                    if (clk_rise) begin
                        wcmd_nxt = d_s2_r;
                        cnt_nxt = '0;
                        ps_nxt = S_ADDR;
                    end
                end
                S_ADDR: begin
                    if (clk_rise) begin
                        pa_nxt = {pa_r[AW-2:0], d_s2_r};
                        cnt_nxt = `PMEM_CNT_W'(cnt_r + 1'b1);
                        if (cnt_r == `PMEM_CNT_W'(AW - 1)) begin
                            cnt_nxt = '0;
                            ps_nxt = wcmd_r ? S_DIN : S_DOUT;
                        end
                    end
                end
                S_DIN: begin
                    if (clk_rise) begin
                        sh_nxt = {sh_r[WW-2:0], d_s2_r};
                        cnt_nxt = `PMEM_CNT_W'(cnt_r + 1'b1);
                        if (cnt_r == `PMEM_CNT_W'(WW - 1)) begin
                            we_nxt = 1'b1;
                            ps_nxt = S_CMD;
                        end
                    end
                end
                S_DOUT: begin
                    // Word loads once the address settles; the address's own fall is skipped
                    if (!drv_r) begin
                        sh_nxt = mbus.rd_data;
                        out_nxt = mbus.rd_data[WW-1];
                        drv_nxt = 1'b1;
                    end else if (clk_fall && cnt_r != '0) begin
                        sh_nxt = {sh_r[WW-2:0], 1'b0};
                        out_nxt = sh_r[WW-2];
                    end else if (clk_rise) begin
                        cnt_nxt = `PMEM_CNT_W'(cnt_r + 1'b1);
                        if (cnt_r == `PMEM_CNT_W'(WW - 1)) begin
                            drv_nxt = 1'b0;
                            ps_nxt = S_CMD;
                        end
                    end
                end
                default: ps_nxt = S_CMD;
            endcase
        end
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ps_r <= S_CMD;
            {cnt_r, pa_r, sh_r, wcmd_r, drv_r, out_r, we_r} <= '0;
        end else begin
            ps_r <= ps_nxt;
            {cnt_r, pa_r, sh_r, wcmd_r, drv_r, out_r, we_r} <=
                {cnt_nxt, pa_nxt, sh_nxt, wcmd_nxt, drv_nxt, out_nxt, we_nxt};
        end
    end
    assign mbus.fetch_addr = pc_r;
    assign mbus.rd_addr = prog_mode ? pa_r : ta_r;
    assign mbus.wr_en = we_r;
    assign mbus.wr_addr = pa_r;
    assign mbus.wr_data = sh_r;
    assign port_a_bit0_o = prog_mode ? out_r : gpio_a0_out;
    assign port_a_bit0_oe_n = prog_mode ? ~drv_r : gpio_a0_oe_n;
    assign port_a_bit2_o = prog_mode ? 1'b0 : gpio_a2_out;
    assign port_a_bit2_oe_n = prog_mode ? 1'b1 : gpio_a2_oe_n;
    assign gpio_a0_in = d_s2_r;
    assign gpio_a2_in = c_s2_r;
    assign program_counter = pc_r;
    assign fetch_word = fw_r;
    assign table_low_ptr = tblp_r;
    assign table_high_ptr = tbhp_r;
    assign table_busy = ts_r == T_READ;
    assign table_done = done_r;
    assign table_done_dest = ddst_r;
    assign table_done_low_byte = lo_r;
    assign table_high_byte_latch = hi_r;
    assign core_suspend = prog_mode;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    sequence s_accept; accept; endsequence
    sequence s_busy_done; table_busy ##1 (table_done && !table_busy); endsequence
    property p_pc_reset; $fell(sys_rst) |-> pc_r == '0; endproperty
    a_pc_reset: assert property (p_pc_reset) else $error("pc not zero after reset");
    property p_two_cycle; s_accept |=> s_busy_done; endproperty
    a_two_cycle: assert property (p_two_cycle) else $error("table read not two cycles");
    // Reset may clear the latch, so the cycle after reset is excused
    property p_latch_ro; !table_done && !$past(sys_rst)
        |-> $stable(table_high_byte_latch); endproperty
    a_latch_ro: assert property (p_latch_ro) else $error("latch changed without read");
    property p_hi_zero; (table_high_byte_latch >> (WW - `PMEM_BYTE_W)) == '0; endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("unused latch bits set");
    property p_full; accept && table_read_mode == MODE_FULL
        |=> ta_r == {$past(tbhp_r[HW-1:0]), $past(tblp_r)}; endproperty
    a_full: assert property (p_full) else $error("full table address wrong");
    property p_page; accept && table_read_mode == MODE_PAGE
        |=> ta_r == {$past(pc_r[AW-1:`PMEM_PAGE_W]), $past(tblp_r)}; endproperty
    a_page: assert property (p_page) else $error("page table address wrong");
    property p_last; accept && table_read_mode == MODE_LAST
        |=> ta_r[AW-1:`PMEM_PAGE_W] == '1 && ta_r[`PMEM_PAGE_W-1:0] == $past(tblp_r);
    endproperty
    a_last: assert property (p_last) else $error("last page address wrong");
    property p_low; table_busy |=> table_done_low_byte == $past(mbus.rd_data[7:0]); endproperty
    a_low: assert property (p_low) else $error("low byte not delivered");
    property p_suspend; prog_mode |=> pc_r == '0 && !table_busy; endproperty
    a_suspend: assert property (p_suspend) else $error("core ran while programming");
    property p_pins; !prog_mode |-> port_a_bit0_oe_n == gpio_a0_oe_n
        && port_a_bit2_oe_n == gpio_a2_oe_n; endproperty
    a_pins: assert property (p_pins) else $error("pins not with user");
endmodule : program_memory_table_read
